// ===== logic/sfr_defs.svh
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
`define SFR_A_FLAGS 5'h00
`define SFR_A_CPDIR 5'h01
`define SFR_A_PADIR 5'h02
`define SFR_A_PAVAL 5'h03
`define SFR_A_PCVAL 5'h04
`define SFR_A_PBDIR 5'h05
`define SFR_A_PBVAL 5'h06
`define SFR_A_SCR1 5'h07
`define SFR_A_AUDLO 5'h08
`define SFR_A_PWMEN 5'h09
`define SFR_A_AUDMID 5'h0A
`define SFR_A_AUDTOP 5'h0B
`define SFR_A_RSV0 5'h0C
`define SFR_A_RSV1 5'h0D
`define SFR_A_PEVAL 5'h0E
`define SFR_A_SCR2 5'h0F
`define SFR_A_GTRIM 5'h10
`define SFR_A_RFCTL 5'h11
`define SFR_A_SPKWK 5'h12
`define SFR_BITOP_MAX 5'h0F
`define SFR_NIB_ZERO 4'h0
`define SFR_FLG_ZERO 0
`define SFR_FLG_CARRY 1
`define SFR_FLG_PWMIRQ 2
`define SFR_PWM_OUTEN 0
`define SFR_PWM_GIE 1
`define SFR_RF_FMT 1
`define SFR_RF_GAIN 3
`define SFR_WK_EN 0
`define SFR_WK_FLAG 3
`define SFR_CLK_HZ 40000000
`define SFR_IRQ_HZ_SLOW 32768
`define SFR_IRQ_HZ_FAST 65536
`define SFR_DIV_W 11
`endif

// ===== logic/sfr_pkg.sv
package sfr_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_set;
        logic bit_clr;
        logic indirect;
        logic [1:0] bit_sel;
        logic [4:0] addr;
        logic [3:0] wdata;
    } sfr_bus_t;
    typedef struct packed {
        logic ten_bit;
        logic twelve_bit;
        logic fast_irq;
        logic combined_bidir;
        logic port_e_bidir;
        logic osc_trim;
    } sfr_opt_t;
    typedef struct packed {
        logic twos_format;
        logic sign;
        logic [11:0] value;
    } sfr_sample_t;
    typedef struct packed {
        logic gain_enable;
        logic [1:0] gain_select;
        logic trim_enable;
        logic [1:0] trim_select;
    } sfr_analog_t;
endpackage : sfr_pkg

// ===== logic/sfr_bank.sv
`timescale 1ns/1ps
`include "sfr_defs.svh"
// Contract
// - direct bit set/clear reaches only 00H-0FH; above needs indirect access
// - 00H: bit2 pwm irq request, bit1 carry, bit0 zero; upper bits reset zero
// - 02H bits make port A pins outputs when 1; reset all inputs
// - 05H bits make port B pins outputs when 1; reset all inputs
// - 01H steers combined port direction only with bidirectional option; code drives PE_OE from it only with both combined_bidir and port_e_bidir set
// - 03H read gives port A pins; write loads port A latch
// - 06H read gives port B pins; write loads port B latch
// - 04H drives port C outputs from written value; resets zero
// - 0EH input-only or bidirectional by option; read pins, write latch
// - 07H and 0FH plain read/write scratch nibbles, no side effects
// - 8-bit sample: 0AH low nibble, 0BH high nibble
// - 10-bit: 08H[3:2] bits 1:0, 0AH bits 5:2, 0BH bits 9:6
// - 12-bit: 08H bits 3:0, 0AH bits 7:4, 0BH bits 11:8
// - top bit of high audio nibble is sign; zero means positive
// - format bit in 11H: 1 two's complement, 0 sign-magnitude
// - 09H bit0 pwm output enable, bit1 global interrupt enable
// - 10H upper bits pick record gain 50..200; 11H bit switches gain on
// - 10H lower bits trim oscillator -4..4 percent when option enabled
// - 12H bit3 wake flag set by speaker wake when bit0 enabled, cleared by software writing 0 to bit3
// - 12H bit0 wake enable; bits 2:1 wake sensitivity low to high
// - interrupt acceptance clears global enable, leaves pwm request set
// - pwm irq request recurs at 32768 Hz, or 65536 Hz with option
module sfr_bank (
    input wire logic CLK,
    input wire logic NRST,
    input wire sfr_pkg::sfr_bus_t BUS,
    output logic [3:0] RDATA,
    input wire sfr_pkg::sfr_opt_t OPT,
    input wire logic ALU_FLAG_WE,
    input wire logic ALU_CARRY,
    input wire logic ALU_ZERO,
    input wire logic IRQ_ACCEPT,
    input wire logic IRQ_RETURN,
    output logic CORE_IRQ,
    input wire logic [3:0] PA_IN,
    output logic [3:0] PA_OUT,
    output logic [3:0] PA_OE,
    input wire logic [3:0] PB_IN,
    output logic [3:0] PB_OUT,
    output logic [3:0] PB_OE,
    output logic [3:0] PC_OUT,
    input wire logic [3:0] PE_IN,
    output logic [3:0] PE_OUT,
    output logic [3:0] PE_OE,
    input wire logic SPK_WAKE,
    output sfr_pkg::sfr_sample_t SAMPLE,
    output logic PWM_OUT_EN,
    output sfr_pkg::sfr_analog_t ANALOG,
    output logic SPK_WAKE_EN,
    output logic [1:0] SPK_WAKE_SENS
);

    // ==========================================
    // helpers
    function automatic logic [3:0] bit_rmw(input logic [3:0] cur,
                                           input logic set_op,
                                           input logic [1:0] sel);
        logic [3:0] m;
        m = 4'h1 << sel;
        if (set_op)
        begin
            bit_rmw = cur | m;
        end
        else
        begin
            bit_rmw = cur & ~m;
        end
    endfunction : bit_rmw

    function automatic logic [11:0] build_sample(input logic [3:0] lo,
                                                 input logic [3:0] mid,
                                                 input logic [3:0] top,
                                                 input logic ten,
                                                 input logic twelve);
        if (twelve)
        begin
            build_sample = {top, mid, lo};
        end
        else if (ten)
        begin
            build_sample = {2'h0, top, mid, lo[3:2]};
        end
        else
        begin
            build_sample = {4'h0, top, mid};
        end
    endfunction : build_sample

    // ==========================================
    // storage
    logic [3:0] flags_q;
    logic [3:0] cpdir_q;
    logic [3:0] padir_q;
    logic [3:0] paval_q;
    logic [3:0] pcval_q;
    logic [3:0] pbdir_q;
    logic [3:0] pbval_q;
    logic [3:0] scr1_q;
    logic [3:0] audlo_q;
    logic [3:0] pwmen_q;
    logic [3:0] audmid_q;
    logic [3:0] audtop_q;
    logic [3:0] peval_q;
    logic [3:0] scr2_q;
    logic [3:0] gtrim_q;
    logic [3:0] rfctl_q;
    logic [3:0] spkwk_q;
    logic [3:0] pa_s1_q;
    logic [3:0] pa_s2_q;
    logic [3:0] pb_s1_q;
    logic [3:0] pb_s2_q;
    logic [3:0] pe_s1_q;
    logic [3:0] pe_s2_q;
    logic wk_s1_q;
    logic wk_s2_q;
    logic wk_s3_q;
    logic [`SFR_DIV_W-1:0] div_q;
    logic tick;
    logic wake_evt;

    // ==========================================
    // write path
    logic bitop_ok;
    logic [3:0] cur_val;
    logic wr_en;
    logic [3:0] wr_val;

    assign bitop_ok = (BUS.bit_set | BUS.bit_clr)
                      & (BUS.indirect | (BUS.addr <= `SFR_BITOP_MAX));

    always_comb
    begin
        unique case (BUS.addr)
            `SFR_A_FLAGS: cur_val = flags_q;
            `SFR_A_CPDIR: cur_val = cpdir_q;
            `SFR_A_PADIR: cur_val = padir_q;
            `SFR_A_PAVAL: cur_val = paval_q;
            `SFR_A_PCVAL: cur_val = pcval_q;
            `SFR_A_PBDIR: cur_val = pbdir_q;
            `SFR_A_PBVAL: cur_val = pbval_q;
            `SFR_A_SCR1: cur_val = scr1_q;
            `SFR_A_AUDLO: cur_val = audlo_q;
            `SFR_A_PWMEN: cur_val = pwmen_q;
            `SFR_A_AUDMID: cur_val = audmid_q;
            `SFR_A_AUDTOP: cur_val = audtop_q;
            `SFR_A_PEVAL: cur_val = peval_q;
            `SFR_A_SCR2: cur_val = scr2_q;
            `SFR_A_GTRIM: cur_val = gtrim_q;
            `SFR_A_RFCTL: cur_val = rfctl_q;
            `SFR_A_SPKWK: cur_val = spkwk_q;
            default: cur_val = `SFR_NIB_ZERO;
        endcase
    end

    always_comb
    begin
        wr_en = BUS.wr | bitop_ok;
        if (BUS.wr)
        begin
            wr_val = BUS.wdata;
        end
        else
        begin
            wr_val = bit_rmw(cur_val, BUS.bit_set, BUS.bit_sel);
        end
    end

    function automatic logic hit(input logic [4:0] a);
        hit = wr_en && (BUS.addr == a);
    endfunction : hit

    // ==========================================
    // pin synchronisers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pa_s1_q <= `SFR_NIB_ZERO;
            pa_s2_q <= `SFR_NIB_ZERO;
            pb_s1_q <= `SFR_NIB_ZERO;
            pb_s2_q <= `SFR_NIB_ZERO;
            pe_s1_q <= `SFR_NIB_ZERO;
            pe_s2_q <= `SFR_NIB_ZERO;
            wk_s1_q <= 1'b0;
            wk_s2_q <= 1'b0;
            wk_s3_q <= 1'b0;
        end
        else
        begin
            pa_s1_q <= PA_IN;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= PB_IN;
            pb_s2_q <= pb_s1_q;
            pe_s1_q <= PE_IN;
            pe_s2_q <= pe_s1_q;
            wk_s1_q <= SPK_WAKE;
            wk_s2_q <= wk_s1_q;
            wk_s3_q <= wk_s2_q;
        end
    end

    assign wake_evt = wk_s2_q & ~wk_s3_q;

    // ==========================================
    // pwm interrupt rate divider
    localparam int DIV_SLOW = `SFR_CLK_HZ / `SFR_IRQ_HZ_SLOW;
    localparam int DIV_FAST = `SFR_CLK_HZ / `SFR_IRQ_HZ_FAST;
    logic [`SFR_DIV_W-1:0] div_last;

    always_comb
    begin
        if (OPT.fast_irq)
        begin
            div_last = `SFR_DIV_W'(DIV_FAST - 1);
        end
        else
        begin
            div_last = `SFR_DIV_W'(DIV_SLOW - 1);
        end
    end

    assign tick = (div_q >= div_last);

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            div_q <= '0;
        end
        else if (tick)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_q + `SFR_DIV_W'(1);
        end
    end

    // ==========================================
    // status flags
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            flags_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_FLAGS))
            begin
                flags_q[`SFR_FLG_ZERO] <= wr_val[`SFR_FLG_ZERO];
                flags_q[`SFR_FLG_CARRY] <= wr_val[`SFR_FLG_CARRY];
            end
            else if (ALU_FLAG_WE)
            begin
                flags_q[`SFR_FLG_ZERO] <= ALU_ZERO;
                flags_q[`SFR_FLG_CARRY] <= ALU_CARRY;
            end
            if (tick)
            begin
                flags_q[`SFR_FLG_PWMIRQ] <= 1'b1;
            end
            else if (hit(`SFR_A_FLAGS))
            begin
                flags_q[`SFR_FLG_PWMIRQ] <= wr_val[`SFR_FLG_PWMIRQ];
            end
        end
    end

    // ==========================================
    // pwm and interrupt enables
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pwmen_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_PWMEN))
            begin
                pwmen_q[`SFR_PWM_OUTEN] <= wr_val[`SFR_PWM_OUTEN];
            end
            if (IRQ_ACCEPT)
            begin
                pwmen_q[`SFR_PWM_GIE] <= 1'b0;
            end
            else if (IRQ_RETURN)
            begin
                pwmen_q[`SFR_PWM_GIE] <= 1'b1;
            end
            else if (hit(`SFR_A_PWMEN))
            begin
                pwmen_q[`SFR_PWM_GIE] <= wr_val[`SFR_PWM_GIE];
            end
        end
    end

    assign CORE_IRQ = flags_q[`SFR_FLG_PWMIRQ] & pwmen_q[`SFR_PWM_GIE];
    assign PWM_OUT_EN = pwmen_q[`SFR_PWM_OUTEN];

    // ==========================================
    // port registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cpdir_q <= `SFR_NIB_ZERO;
            padir_q <= `SFR_NIB_ZERO;
            pbdir_q <= `SFR_NIB_ZERO;
            pcval_q <= `SFR_NIB_ZERO;
            paval_q <= `SFR_NIB_ZERO;
            pbval_q <= `SFR_NIB_ZERO;
            peval_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_CPDIR))
            begin
                cpdir_q <= wr_val;
            end
            if (hit(`SFR_A_PADIR))
            begin
                padir_q <= wr_val;
            end
            if (hit(`SFR_A_PBDIR))
            begin
                pbdir_q <= wr_val;
            end
            if (hit(`SFR_A_PCVAL))
            begin
                pcval_q <= wr_val;
            end
            if (hit(`SFR_A_PAVAL))
            begin
                paval_q <= wr_val;
            end
            if (hit(`SFR_A_PBVAL))
            begin
                pbval_q <= wr_val;
            end
            if (hit(`SFR_A_PEVAL))
            begin
                peval_q <= wr_val;
            end
        end
    end

    assign PA_OUT = paval_q;
    assign PA_OE = padir_q;
    assign PB_OUT = pbval_q;
    assign PB_OE = pbdir_q;
    assign PC_OUT = pcval_q;
    assign PE_OUT = peval_q;
    assign PE_OE = (OPT.combined_bidir & OPT.port_e_bidir) ? cpdir_q
                   : `SFR_NIB_ZERO;

    // ==========================================
    // scratch and audio registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            scr1_q <= `SFR_NIB_ZERO;
            scr2_q <= `SFR_NIB_ZERO;
            audlo_q <= `SFR_NIB_ZERO;
            audmid_q <= `SFR_NIB_ZERO;
            audtop_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_SCR1))
            begin
                scr1_q <= wr_val;
            end
            if (hit(`SFR_A_SCR2))
            begin
                scr2_q <= wr_val;
            end
            if (hit(`SFR_A_AUDLO))
            begin
                audlo_q <= wr_val;
            end
            if (hit(`SFR_A_AUDMID))
            begin
                audmid_q <= wr_val;
            end
            if (hit(`SFR_A_AUDTOP))
            begin
                audtop_q <= wr_val;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            SAMPLE <= '0;
        end
        else
        begin
            SAMPLE.value <= build_sample(audlo_q, audmid_q, audtop_q,
                                         OPT.ten_bit, OPT.twelve_bit);
            SAMPLE.sign <= audtop_q[3];
            SAMPLE.twos_format <= rfctl_q[`SFR_RF_FMT];
        end
    end

    // ==========================================
    // analog control and speaker wake
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            gtrim_q <= `SFR_NIB_ZERO;
            rfctl_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_GTRIM))
            begin
                gtrim_q <= wr_val;
            end
            if (hit(`SFR_A_RFCTL))
            begin
                rfctl_q <= wr_val;
            end
        end
    end

    assign ANALOG.gain_enable = rfctl_q[`SFR_RF_GAIN];
    assign ANALOG.gain_select = gtrim_q[3:2];
    assign ANALOG.trim_enable = OPT.osc_trim;
    assign ANALOG.trim_select = OPT.osc_trim ? gtrim_q[1:0] : 2'h0;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            spkwk_q <= `SFR_NIB_ZERO;
        end
        else
        begin
            if (hit(`SFR_A_SPKWK))
            begin
                spkwk_q[2:0] <= wr_val[2:0];
            end
            if (wake_evt && spkwk_q[`SFR_WK_EN])
            begin
                spkwk_q[`SFR_WK_FLAG] <= 1'b1;
            end
            else if (hit(`SFR_A_SPKWK) && !wr_val[`SFR_WK_FLAG])
            begin
                spkwk_q[`SFR_WK_FLAG] <= 1'b0;
            end
        end
    end

    assign SPK_WAKE_EN = spkwk_q[`SFR_WK_EN];
    assign SPK_WAKE_SENS = spkwk_q[2:1];

    // ==========================================
    // read path
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RDATA <= `SFR_NIB_ZERO;
        end
        else if (BUS.rd)
        begin
            unique case (BUS.addr)
                `SFR_A_FLAGS: RDATA <= {1'b0, flags_q[2:0]};
                `SFR_A_PAVAL: RDATA <= pa_s2_q;
                `SFR_A_PBVAL: RDATA <= pb_s2_q;
                `SFR_A_PEVAL: RDATA <= pe_s2_q;
                `SFR_A_PWMEN: RDATA <= {2'h0, pwmen_q[1:0]};
                `SFR_A_AUDLO, `SFR_A_AUDMID, `SFR_A_AUDTOP,
                `SFR_A_RSV0, `SFR_A_RSV1: RDATA <= `SFR_NIB_ZERO;
                default: RDATA <= cur_val;
            endcase
        end
    end

endmodule : sfr_bank

// ===== sim/sfr_bank_props.sv
`timescale 1ns/1ps
// ==========
// port checker
module sfr_bank_props (
    input wire logic CLK,
    input wire logic NRST,
    input wire sfr_pkg::sfr_bus_t BUS,
    input wire logic [3:0] RDATA,
    input wire sfr_pkg::sfr_opt_t OPT,
    input wire logic IRQ_ACCEPT,
    input wire logic CORE_IRQ,
    input wire logic [3:0] PA_OE,
    input wire logic [3:0] PC_OUT,
    input wire logic [3:0] PE_OE,
    input wire sfr_pkg::sfr_sample_t SAMPLE,
    input wire logic PWM_OUT_EN,
    input wire sfr_pkg::sfr_analog_t ANALOG,
    input wire logic SPK_WAKE_EN
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // ==========
    // named steps
    sequence s_wr(logic [4:0] a);
        BUS.wr && BUS.addr == a;
    endsequence
    sequence s_bit_high;
        (BUS.bit_set || BUS.bit_clr) && !BUS.indirect && !BUS.wr && BUS.addr == 5'h10;
    endsequence
    // ==========
    // assertions
    a_pa_dir_write: assert property (s_wr(5'h02) |=> PA_OE == $past(BUS.wdata))
        else $error("port a direction not loaded");
    a_pc_out_write: assert property (s_wr(5'h04) |=> PC_OUT == $past(BUS.wdata))
        else $error("port c latch not loaded");
    a_bit_op_range: assert property (s_bit_high |=> $stable(ANALOG.gain_select))
        else $error("direct bit op reached 10H");
    a_reserved_read: assert property (BUS.rd && BUS.addr inside {5'h0C, 5'h0D}
        |=> RDATA == 4'h0) else $error("reserved read not zero");
    a_accept_clears_irq: assert property (IRQ_ACCEPT |=> !CORE_IRQ)
        else $error("irq still raised after accept");
    a_pwm_enable_bit: assert property (s_wr(5'h09) |=> PWM_OUT_EN == $past(BUS.wdata[0]))
        else $error("pwm enable not loaded");
    a_wake_enable_bit: assert property (s_wr(5'h12) |=> SPK_WAKE_EN == $past(BUS.wdata[0]))
        else $error("wake enable not loaded");
    a_twelve_top_sign: assert property (s_wr(5'h0B) ##0 OPT.twelve_bit |=> ##1
        (SAMPLE.value[11:8] == $past(BUS.wdata, 2) && SAMPLE.sign == $past(BUS.wdata[3], 2)))
        else $error("twelve bit top nibble wrong");
    a_eight_low_nib: assert property (s_wr(5'h0A) ##0 !(OPT.ten_bit || OPT.twelve_bit)
        |=> ##1 (SAMPLE.value[3:0] == $past(BUS.wdata, 2) && SAMPLE.value[11:8] == 4'h0))
        else $error("eight bit sample wrong");
    a_pe_oe_gated: assert property (!(OPT.combined_bidir && OPT.port_e_bidir) [*3]
        |-> PE_OE == 4'h0) else $error("port e driven without option");
endmodule : sfr_bank_props

bind sfr_bank sfr_bank_props u_props (
    .CLK(CLK),
    .NRST(NRST),
    .BUS(BUS),
    .RDATA(RDATA),
    .OPT(OPT),
    .IRQ_ACCEPT(IRQ_ACCEPT),
    .CORE_IRQ(CORE_IRQ),
    .PA_OE(PA_OE),
    .PC_OUT(PC_OUT),
    .PE_OE(PE_OE),
    .SAMPLE(SAMPLE),
    .PWM_OUT_EN(PWM_OUT_EN),
    .ANALOG(ANALOG),
    .SPK_WAKE_EN(SPK_WAKE_EN)
);

// ===== sim/speech_mcu_sfr_bank_bench.sv
`timescale 1ns/1ps
// ==========
// register bank bench
module speech_mcu_sfr_bank_bench;
    localparam logic [4:0] K_RD = 5'h10;
    localparam logic [4:0] K_WR = 5'h08;
    localparam logic [4:0] K_SET = 5'h04;
    localparam logic [4:0] K_CLR = 5'h02;
    localparam logic [4:0] K_IND = 5'h01;
    logic clk, nrst, alu_we, alu_carry, alu_zero, irq_accept, irq_return, core_irq;
    logic spk_wake, pwm_out_en, spk_wake_en;
    logic [1:0] spk_wake_sens;
    logic [3:0] rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_out, pe_in, pe_out, pe_oe;
    sfr_pkg::sfr_bus_t bus;
    sfr_pkg::sfr_opt_t opt;
    sfr_pkg::sfr_sample_t sample;
    sfr_pkg::sfr_analog_t analog;
    int fail_count;
    int comparisons;
    int cyc;
    sfr_bank u_dut (.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .OPT(opt),
        .ALU_FLAG_WE(alu_we), .ALU_CARRY(alu_carry), .ALU_ZERO(alu_zero),
        .IRQ_ACCEPT(irq_accept), .IRQ_RETURN(irq_return), .CORE_IRQ(core_irq),
        .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out),
        .PB_OE(pb_oe), .PC_OUT(pc_out), .PE_IN(pe_in), .PE_OUT(pe_out), .PE_OE(pe_oe),
        .SPK_WAKE(spk_wake), .SAMPLE(sample), .PWM_OUT_EN(pwm_out_en), .ANALOG(analog),
        .SPK_WAKE_EN(spk_wake_en), .SPK_WAKE_SENS(spk_wake_sens));
    // ==========
    // clock and cycle count
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ==========
    // tasks
    task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task op(input logic [4:0] k, input logic [1:0] s, input logic [4:0] a, input logic [3:0] d);
        @(posedge clk);
        bus <= {k, s, a, d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : op
    task wr(input logic [4:0] a, input logic [3:0] d);
        op(K_WR, 2'h0, a, d);
    endtask : wr
    task rd_check(input string nm, input logic [4:0] a, input logic [3:0] exp);
        op(K_RD, 2'h0, a, 4'h0);
        check(nm, 12'(rdata), 12'(exp));
    endtask : rd_check
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task wait_irq(output int t);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge clk);
            #1;
            if (core_irq === 1'b1)
                break;
        end
        if (i == 3000)
        begin
            fail_count++;
            print_verdict();
        end
        t = cyc;
    endtask : wait_irq
    // ==========
    // main sequence
    initial
    begin
        logic [4:0] zaddr [0:11];
        logic [11:0] sexp [0:2];
        int t1;
        int t2;
        int m;
        zaddr = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h0C, 5'h0D,
            5'h10, 5'h11, 5'h12};
        sexp = '{12'h0B9, 12'h2E5, 12'hB96};
        {fail_count, comparisons, cyc} = '0;
        {nrst, alu_we, alu_carry, alu_zero, irq_accept, irq_return, spk_wake} = '0;
        {pa_in, pb_in, pe_in} = '0;
        bus = '0;
        opt = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (m = 0; m < 12; m++)
            rd_check("reset_value", zaddr[m], 4'h0);
        alu_we <= 1'b1;
        alu_carry <= 1'b1;
        @(posedge clk);
        alu_we <= 1'b0;
        rd_check("alu_flags", 5'h00, 4'h2);
        wr(5'h07, 4'hA);
        wr(5'h0F, 4'h5);
        rd_check("scratch_two", 5'h0F, 4'h5);
        op(K_SET, 2'h0, 5'h07, 4'h0);
        rd_check("bit_set_low", 5'h07, 4'hB);
        op(K_CLR, 2'h2, 5'h0F, 4'h0);
        rd_check("bit_clr_low", 5'h0F, 4'h1);
        op(K_SET, 2'h3, 5'h10, 4'h0);
        rd_check("bit_set_high", 5'h10, 4'h0);
        op(K_SET | K_IND, 2'h3, 5'h10, 4'h0);
        rd_check("bit_set_indirect", 5'h10, 4'h8);
        wr(5'h02, 4'hF);
        wr(5'h03, 4'h6);
        wr(5'h05, 4'h3);
        wr(5'h06, 4'h9);
        wr(5'h04, 4'hC);
        wr(5'h0E, 4'h3);
        wr(5'h01, 4'h5);
        check("pa_ports", {4'h0, pa_oe, pa_out}, 12'h0F6);
        check("pb_ports", {pc_out, pb_oe, pb_out}, 12'hC39);
        check("pe_ports", {4'h0, pe_oe, pe_out}, 12'h003);
        pa_in <= 4'h9;
        pb_in <= 4'h4;
        pe_in <= 4'hA;
        opt.combined_bidir <= 1'b1;
        opt.port_e_bidir <= 1'b1;
        settle(3);
        check("pe_oe_on", 12'(pe_oe), 12'h005);
        rd_check("pa_pins", 5'h03, 4'h9);
        rd_check("pb_pins", 5'h06, 4'h4);
        rd_check("pe_pins", 5'h0E, 4'hA);
        for (m = 0; m < 3; m++)
        begin
            opt.ten_bit <= (m > 0);
            opt.twelve_bit <= (m == 2);
            wr(5'h08, 4'h6);
            wr(5'h0A, 4'h9);
            wr(5'h0B, 4'hB);
            settle(1);
            check("sample", sample.value, sexp[m]);
            check("sample_sign", 12'(sample.sign), 12'h001);
        end
        wr(5'h11, 4'hA);
        wr(5'h10, 4'h9);
        settle(1);
        check("format_gain", 12'({sample.twos_format, analog}), 12'h070);
        opt.osc_trim <= 1'b1;
        settle(1);
        check("trim_on", 12'(analog), 12'h035);
        wr(5'h09, 4'h1);
        check("pwm_on", 12'(pwm_out_en), 12'h001);
        wr(5'h09, 4'h2);
        wait_irq(t1);
        wr(5'h00, 4'h0);
        wait_irq(t2);
        check("irq_period", 12'(t2 - t1), 12'h4C4);
        opt.fast_irq <= 1'b1;
        wr(5'h00, 4'h0);
        wait_irq(t1);
        wr(5'h00, 4'h0);
        wait_irq(t2);
        check("irq_fast", 12'(t2 - t1), 12'h262);
        irq_accept <= 1'b1;
        @(posedge clk);
        irq_accept <= 1'b0;
        #1;
        check("irq_accepted", 12'(core_irq), 12'h000);
        rd_check("request_kept", 5'h00, 4'h4);
        rd_check("gie_cleared", 5'h09, 4'h0);
        wr(5'h12, 4'h7);
        check("wake_ctrl", 12'({spk_wake_en, spk_wake_sens}), 12'h007);
        spk_wake <= 1'b1;
        settle(5);
        rd_check("wake_set", 5'h12, 4'hF);
        wr(5'h12, 4'hF);
        rd_check("wake_kept", 5'h12, 4'hF);
        wr(5'h12, 4'h3);
        rd_check("wake_cleared", 5'h12, 4'h3);
        print_verdict();
    end
endmodule : speech_mcu_sfr_bank_bench
